// >>> src/twr_defs.vh
// Overview of operation
// RULE_01: every address and data byte moves most significant bit first.
// RULE_02: a write byte not acknowledged leaves the data line released high.
// RULE_03: master not acknowledging a read byte ends reading; data line released.
// RULE_04: first write byte after the slave address loads the base register address.
// RULE_05: first data byte hits base address, each later one the next address.
// RULE_06: address stops incrementing at the highest implemented register.
// RULE_07: a base address above the highest register is not acknowledged.
// RULE_08: master loads the base address by a write holding only that byte.
// RULE_09: a read starts at the base address last loaded by a write.
// RULE_10: reading advances the register address after every byte sent.
// RULE_11: data rising while clock high is a stop; slave returns to idle.
// RULE_12: repeated start restarts address decoding, keeping the stored base address.
// RULE_13: first byte is 7-bit address plus direction; match acknowledged on ninth pulse.
// RULE_14: data falling while clock high is a start, recognised from idle.
// RULE_15: data changes while clock low; changes while clock high are start or stop.
// RULE_16: the answered slave address depends on the address select pin.
// RULE_17: a written byte is committed when its acknowledge is given.
`ifndef TWR_DEFS_VH
`define TWR_DEFS_VH

// seven-bit slave address with the select pin as lowest bit
`define TWR_SLAVE_ADDR_HI 6'h26
`define TWR_MAX_REG_ADDR 8'hee
`define TWR_BASE_RESET 8'h00
`define TWR_BIT_LAST 4'h7
`define TWR_BIT_FIRST 4'h0
`define TWR_BYTE_BITS 4'h8
`define TWR_CNT_STEP 4'h1
`define TWR_ADDR_STEP 8'h01
`define TWR_DIR_READ 1'b1
`define TWR_DRIVE_LEVEL 1'b0

`endif

// >>> src/twr_line_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for the bus lines, plus one stage for edge finding
module twr_line_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // lines
  input wire [WIDTH-1:0] line_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] prev_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [WIDTH-1:0] prev_q;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
      prev_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= line_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign prev_o = prev_q;
endmodule // twr_line_sync
`default_nettype wire

// >>> src/twr_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "twr_defs.vh"
module twr_slave #(
  parameter REG_COUNT = 239
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // serial bus
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // strap
  input wire address_select_pin_i,
  // register side
  output reg [7:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_we_o,
  input wire [7:0] reg_rdata_i,
  output reg busy_o
);
  // ==========================================================
  // state codes
  localparam ST_IDLE = 4'h0;
  localparam ST_DEV = 4'h1;
  localparam ST_DEV_ACK = 4'h2;
  localparam ST_WADDR = 4'h3;
  localparam ST_WDATA = 4'h4;
  localparam ST_WACK = 4'h5;
  localparam ST_RDATA = 4'h6;
  localparam ST_RACK = 4'h7;

  // ==========================================================
  // address range
  // the register count sets the saturation point of the auto-increment
  localparam [31:0] LAST_REG = REG_COUNT - `TWR_ADDR_STEP;
  wire [7:0] max_addr;
  assign max_addr = LAST_REG[7:0];

  // ==========================================================
  // synchronised pins
  // select pin, clock and data each pass two flops before use
  wire [2:0] lvl;
  wire [2:0] prv;
  twr_line_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .line_i({address_select_pin_i, scl_i, sda_i}),
    .level_o(lvl),
    .prev_o(prv)
  );

  // previous levels give the edges and the start and stop conditions
  wire sel;
  wire scl;
  wire sda;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  assign sel = lvl[2];
  assign scl = lvl[1];
  assign sda = lvl[0];
  assign scl_rise = lvl[1] & ~prv[1];
  assign scl_fall = ~lvl[1] & prv[1];
  // data moving while clock stays high is a condition, not data
  assign start_det = scl & prv[1] & prv[0] & ~sda; // [RULE_14] [RULE_15]
  assign stop_det = scl & prv[1] & ~prv[0] & sda; // [RULE_11] [RULE_15]

  // ==========================================================
  // decoding shared by several branches
  // saturating increment used by the write and the read path
  function [7:0] next_addr;
    input [7:0] a;
    input [7:0] top;
    begin
      if (a >= top)
        next_addr = top; // [RULE_06]
      else
        next_addr = a + `TWR_ADDR_STEP;
    end
  endfunction

  // slave address match, low address bit taken from the select pin
  function addr_match;
    input [6:0] a;
    input s;
    begin
      addr_match = (a == {`TWR_SLAVE_ADDR_HI, s}); // [RULE_16]
    end
  endfunction

  // ==========================================================
  // registers
  reg [3:0] state_q;
  reg [3:0] state_d;
  // bit counter within the current byte
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  // shift register, receive and transmit
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  // stored base address survives repeated starts
  reg [7:0] base_q;
  reg [7:0] base_d;
  // direction bit of the last matched address byte
  reg dir_q;
  reg dir_d;
  // master acknowledged the last read byte
  reg ack_q;
  reg ack_d;
  // pull the data pin low
  reg drive_q;
  reg drive_d;
  // next values of the register side outputs
  reg [7:0] addr_d;
  reg [7:0] wdata_d;
  reg we_d;
  reg busy_d;

  // ==========================================================
  // next state
  // bus events reach this logic about three clocks after the pins;
  // the bus clock must stay low long enough for that lag, which the
  // eight-clock link period leaves room for.
  // read data is taken from reg_rdata_i a whole bus bit after reg_addr_o
  // moves, so the register file may decode it combinationally
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    base_d = base_q;
    dir_d = dir_q;
    ack_d = ack_q;
    drive_d = drive_q;
    addr_d = reg_addr_o;
    wdata_d = reg_wdata_o;
    we_d = 1'b0;
    busy_d = busy_o;
    if (start_det) begin
      // repeated start keeps base_q untouched
      state_d = ST_DEV; // [RULE_12]
      cnt_d = `TWR_BIT_FIRST;
      ack_d = 1'b0;
      drive_d = 1'b0;
      busy_d = 1'b1;
    end else if (stop_det) begin
      state_d = ST_IDLE; // [RULE_11]
      ack_d = 1'b0;
      drive_d = 1'b0;
      busy_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // wait here until a start condition
          drive_d = 1'b0;
        end
        ST_DEV, ST_WADDR, ST_WDATA: begin
          // a byte is complete at the clock fall after its eighth bit
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda}; // [RULE_01]
            cnt_d = cnt_q + `TWR_CNT_STEP;
          end else if (scl_fall && cnt_q == `TWR_BYTE_BITS) begin
            cnt_d = `TWR_BIT_FIRST;
            if (state_q == ST_DEV) begin
              if (addr_match(shift_q[7:1], sel)) begin // [RULE_13]
                // register address is set up now so read data settles early
                drive_d = 1'b1;
                dir_d = shift_q[0];
                addr_d = base_q; // [RULE_09]
                state_d = ST_DEV_ACK;
              end else begin
                state_d = ST_IDLE;
              end
            end else if (state_q == ST_WADDR) begin
              if (shift_q > max_addr) begin
                // line stays released, master may stop
                state_d = ST_IDLE; // [RULE_07] [RULE_02]
              end else begin
                base_d = shift_q; // [RULE_04] [RULE_08]
                addr_d = shift_q;
                drive_d = 1'b1;
                state_d = ST_WACK;
              end
            end else begin
              // byte is committed with its acknowledge, not at stop
              wdata_d = shift_q;
              addr_d = base_q; // [RULE_05]
              we_d = 1'b1; // [RULE_17]
              base_d = next_addr(base_q, max_addr); // [RULE_05] [RULE_06]
              drive_d = 1'b1;
              state_d = ST_WACK;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            cnt_d = `TWR_BIT_FIRST;
            if (dir_q == `TWR_DIR_READ) begin
              // first bit goes out as the acknowledge pulse ends
              shift_d = {reg_rdata_i[6:0], 1'b0};
              drive_d = ~reg_rdata_i[7]; // [RULE_01]
              state_d = ST_RDATA;
            end else begin
              // next byte is the base register address
              drive_d = 1'b0;
              state_d = ST_WADDR;
            end
          end
        end
        ST_WACK: begin
          // release the acknowledge and wait for the next data byte
          if (scl_fall) begin
            drive_d = 1'b0;
            cnt_d = `TWR_BIT_FIRST;
            state_d = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == `TWR_BIT_LAST) begin
              // release for the master's acknowledge, next register selected
              drive_d = 1'b0;
              base_d = next_addr(base_q, max_addr); // [RULE_10] [RULE_06]
              addr_d = next_addr(base_q, max_addr);
              state_d = ST_RACK;
            end else begin
              drive_d = ~shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
              cnt_d = cnt_q + `TWR_CNT_STEP;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda) begin
              // no acknowledge: end of data, line stays released
              state_d = ST_IDLE; // [RULE_03]
            end else begin
              ack_d = 1'b1;
            end
          end else if (scl_fall && ack_q) begin
            ack_d = 1'b0;
            cnt_d = `TWR_BIT_FIRST;
            shift_d = {reg_rdata_i[6:0], 1'b0};
            drive_d = ~reg_rdata_i[7]; // [RULE_10]
            state_d = ST_RDATA;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // state registers
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= `TWR_BIT_FIRST;
      shift_q <= 8'h00;
      base_q <= `TWR_BASE_RESET;
      dir_q <= 1'b0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      base_q <= base_d;
      dir_q <= dir_d;
      ack_q <= ack_d;
      drive_q <= drive_d;
    end
  end

  // ==========================================================
  // register side outputs
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_addr_o <= `TWR_BASE_RESET;
      reg_wdata_o <= 8'h00;
      reg_we_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      // write strobe is a single-cycle pulse
      reg_addr_o <= addr_d;
      reg_wdata_o <= wdata_d;
      reg_we_o <= we_d;
      busy_o <= busy_d;
    end
  end

  // ==========================================================
  // serial data pin: open drain, only ever pulls low
  assign sda_o = `TWR_DRIVE_LEVEL;
  assign sda_oe_o = drive_q;
endmodule // twr_slave
`default_nettype wire

// >>> testbench/twr_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module twr_bus_master (
  // serial bus, clock stands high outside frames
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  logic s;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic xfer(input logic b, output logic r);
    sda_low_o = !b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask
  task automatic start;
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask
  task automatic stop;
    sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_low_o = 1'b0;
    #80;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) xfer(d[i], s);
    xfer(1'b1, s);
    ack = !s;
  endtask
  task automatic get(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(!ack, s);
  endtask
endmodule // twr_bus_master
`default_nettype wire

// >>> testbench/twr_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module twr_slave_bench;
  logic clock_i, rst_i, sel, scl, sda_low, sda_o, sda_oe_o, we, busy, ack;
  logic [7:0] addr, wdata, d;
  logic [7:0] rf [0:255];
  int miscompares = 0;
  int n_checks = 0;
  wire logic sda = !(sda_low | (sda_oe_o & !sda_o));
  twr_slave dut_u (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .address_select_pin_i(sel), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_we_o(we), .reg_rdata_i(rf[addr]), .busy_o(busy));
  twr_bus_master m_u (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  always @(posedge clock_i) if (we) rf[addr] <= wdata;
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = !clock_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] v, input logic exp_ack);
    m_u.put(v, ack);
    chk("ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask
  task automatic t_write;
    m_u.start();
    send(8'h9a, 1'b1);
    send(8'hec, 1'b1);
    send(8'h11, 1'b1);
    chk("commit", 8'h11, rf[8'hec]);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    send(8'h44, 1'b1);
    m_u.stop();
    repeat (8) @(posedge clock_i);
    chk("reg ed", 8'h22, rf[8'hed]);
    chk("reg ee", 8'h44, rf[8'hee]);
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic t_refuse;
    m_u.start();
    send(8'h98, 1'b0);
    m_u.stop();
    m_u.start();
    send(8'h9a, 1'b1);
    send(8'hef, 1'b0);
    chk("line", 8'h01, {7'h00, sda});
    m_u.stop();
    @(posedge clock_i);
    #1 sel = 1'b0;
    m_u.start();
    send(8'h98, 1'b1);
    m_u.stop();
    #1 sel = 1'b1;
  endtask
  task automatic t_read;
    m_u.start();
    send(8'h9a, 1'b1);
    send(8'hec, 1'b1);
    m_u.start();
    send(8'h9b, 1'b1);
    m_u.get(1'b1, d);
    chk("rd ec", 8'h11, d);
    m_u.get(1'b1, d);
    chk("rd ed", 8'h22, d);
    m_u.get(1'b0, d);
    chk("rd ee", 8'h44, d);
    repeat (4) @(posedge clock_i);
    chk("release", 8'h01, {7'h00, sda});
    m_u.stop();
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    sel = 1'b1;
    repeat (20) @(posedge clock_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    t_write();
    t_refuse();
    t_read();
    conclude();
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // twr_slave_bench
`default_nettype wire

// >>> testbench/twr_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
module twr_slave_chk (
  // watched ports
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_wdata_o,
  input wire logic reg_we_o,
  input wire logic busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_drive_low: assert property ($rose(sda_oe_o) |-> !scl_i && sda_o == 1'b0)
    else $error("data pin pulled outside clock low");
  a_we_single: assert property (reg_we_o |=> !reg_we_o)
    else $error("write strobe too long");
  a_we_range: assert property (reg_we_o |-> busy_o && reg_addr_o <= 8'hee)
    else $error("write outside transfer or range");
  a_we_hold: assert property (reg_we_o |=> $stable(reg_addr_o) && $stable(reg_wdata_o))
    else $error("write target moved");
  a_start_busy: assert property (!busy_o && scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] busy_o)
    else $error("start missed");
  a_stop_idle: assert property (busy_o && scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !busy_o)
    else $error("stop missed");
  a_oe_steady: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe_o))
    else $error("data changed with clock high");
  a_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
    else $error("data driven while idle");
  c_write: cover property (reg_we_o);
  c_ack: cover property ($rose(sda_oe_o));
  c_stop: cover property ($fell(busy_o));
endmodule // twr_slave_chk
bind twr_slave twr_slave_chk chk_u (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
  .reg_we_o(reg_we_o), .busy_o(busy_o));
`default_nettype wire
